// *** sbsp_pkg.sv ***
package sbsp_pkg;

   // Array organisation
   localparam int LANES     = 4;
   localparam int LANE_W    = 9;
   localparam int DATA_W    = 36;
   localparam int BURST_W   = 2;
   localparam int ADDR_HI_W = 8;
   localparam int ADDR_W    = 10;
   localparam int DEPTH     = 1024;

   // Lane masks for the two organisations
   localparam logic [3:0] FULL_LANE_MASK   = 4'hf;
   localparam logic [3:0] NARROW_LANE_MASK = 4'h3;

   // Sleep entry and wake delay, in clock cycles
   localparam int               SLEEP_CYCLES  = 2;
   localparam logic [1:0]       SLEEP_CNT_MAX = 2'(SLEEP_CYCLES - 1);

   // Synchroniser reset: {outputEnable_n, linearOrderSelect_n, sleepRequest}
   localparam logic [2:0] SYNC_RST = 3'h4;
   localparam int         SYNC_OE   = 2;
   localparam int         SYNC_LBO  = 1;
   localparam int         SYNC_ZZ   = 0;

   // Operation kind of the burst in progress
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_READ,
      OP_WRITE
   } sbsp_op_t;

   // Burst address for a given step from the loaded start
   function automatic logic [BURST_W-1:0] sbspBurstSeq(
      input logic [BURST_W-1:0] start,
      input logic [BURST_W-1:0] step,
      input logic               linear);
      sbspBurstSeq = linear ? BURST_W'(start + step) : (start ^ step);
   endfunction

endpackage

// *** sbsp_burst_ctr.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbsp_burst_ctr
   import sbsp_pkg::*;
(
   // Clock and reset
   input  wire  logic               clk,
   input  wire  logic               reset_n,
   // Control
   input  wire  logic               load,
   input  wire  logic               advance,
   input  wire  logic               linearOrder,
   input  wire  logic [BURST_W-1:0] startBits,
   // Address of the next continue cycle
   output logic       [BURST_W-1:0] nextBits
);

   logic [BURST_W-1:0] base_q;
   logic [BURST_W-1:0] step_q;
   logic [BURST_W-1:0] stepNext;

   assign stepNext = BURST_W'(step_q + 2'h1);

   // Four addresses then wrap to the loaded one
   assign nextBits = sbspBurstSeq(base_q, stepNext, linearOrder);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         base_q <= '0;
         step_q <= '0;
      end else if (load) begin
         base_q <= startBits;
         step_q <= '0;
      end else if (advance) begin
         step_q <= stepNext;
      end
   end

endmodule // sbsp_burst_ctr

`default_nettype wire

// *** sbsp_mem_core.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbsp_mem_core
   import sbsp_pkg::*;
(
   // Clock
   input  wire  logic              clk,
   // Write port
   input  wire  logic              wrEn,
   input  wire  logic [ADDR_W-1:0] wrAddr,
   input  wire  logic [LANES-1:0]  wrLanes,
   input  wire  logic [DATA_W-1:0] wrData,
   // Read port
   input  wire  logic [ADDR_W-1:0] rdAddr,
   output logic       [DATA_W-1:0] rdData
);

   logic [DATA_W-1:0] mem [DEPTH];

   assign rdData = mem[rdAddr];

   // Only selected byte lanes are written
   always_ff @(posedge clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (wrEn && wrLanes[i]) begin
            mem[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
         end
      end
   end

endmodule // sbsp_mem_core

`default_nettype wire

// *** sbsp_port.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbsp_port
   import sbsp_pkg::*;
(
   // Clock and reset
   input  wire  logic                 clk,
   input  wire  logic                 reset_n,
   // Clock gate
   input  wire  logic                 clockGate_n,
   // Chip selects
   input  wire  logic                 chipSelectOne_n,
   input  wire  logic                 chipSelectTwo,
   input  wire  logic                 chipSelectThree_n,
   // Command
   input  wire  logic                 storeStrobe_n,
   input  wire  logic                 burstStepOrLoad,
   // Address
   input  wire  logic [ADDR_HI_W-1:0] addrHigh,
   input  wire  logic [BURST_W-1:0]   burstStartLowBits,
   // Byte lane strobes
   input  wire  logic                 byteLaneAStrobe_n,
   input  wire  logic                 byteLaneBStrobe_n,
   input  wire  logic                 byteLaneCStrobe_n,
   input  wire  logic                 byteLaneDStrobe_n,
   // Mode and power pins
   input  wire  logic                 outputEnable_n,
   input  wire  logic                 sleepRequest,
   input  wire  logic                 flowThroughSelect_n,
   input  wire  logic                 linearOrderSelect_n,
   input  wire  logic                 narrowOrg,
   // Write data from the pins
   input  wire  logic [LANE_W-1:0]    dataLaneAIn,
   input  wire  logic [LANE_W-1:0]    dataLaneBIn,
   input  wire  logic [LANE_W-1:0]    dataLaneCIn,
   input  wire  logic [LANE_W-1:0]    dataLaneDIn,
   // Read data to the pins
   output logic       [LANE_W-1:0]    dataLaneAOut,
   output logic       [LANE_W-1:0]    dataLaneBOut,
   output logic       [LANE_W-1:0]    dataLaneCOut,
   output logic       [LANE_W-1:0]    dataLaneDOut,
   output logic                       dataOe,
   // Status
   output logic                       asleep
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [2:0]           syncMeta_q;
   logic [2:0]           sync_q;
   logic                 oeSync_n;
   logic                 linearSync;
   logic                 sleepSync;

   logic [1:0]           sleepCnt_q;
   logic                 asleep_q;

   logic                 run;
   logic                 flowMode;
   logic                 selected;
   logic                 loadCmd;
   logic                 contCmd;
   logic                 newRead;
   logic                 newWrite;
   logic                 rdNow;
   logic                 wrNow;
   logic                 wrEff;
   logic [LANES-1:0]     laneMask;
   logic [LANES-1:0]     strobe_n;

   sbsp_op_t             op_q;
   logic [ADDR_HI_W-1:0] hi_q;
   logic [BURST_W-1:0]   nextBits;
   logic [ADDR_W-1:0]    accAddr;

   logic [DATA_W-1:0]    rdData;
   logic [DATA_W-1:0]    rdStage_q;
   logic                 rdValid1_q;
   logic [DATA_W-1:0]    dataOut_q;
   logic                 drive_q;
   logic                 driveNext;
   logic                 dataOe_q;

   logic                 wrV1_q;
   logic [ADDR_W-1:0]    wrA1_q;
   logic [LANES-1:0]     wrM1_q;
   logic                 wrV2_q;
   logic [ADDR_W-1:0]    wrA2_q;
   logic [LANES-1:0]     wrM2_q;
   logic                 commitEn;
   logic [ADDR_W-1:0]    commitAddr;
   logic [LANES-1:0]     commitMask;
   logic [DATA_W-1:0]    dataIn;

   ////////////////////////////////////////////////////////////////////////////
   // Asynchronous pins through two flip-flops

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncMeta_q <= SYNC_RST;
         sync_q     <= SYNC_RST;
      end else begin
         syncMeta_q <= {outputEnable_n, linearOrderSelect_n, sleepRequest};
         sync_q     <= syncMeta_q;
      end
   end

   assign oeSync_n   = sync_q[SYNC_OE];
   assign linearSync = !sync_q[SYNC_LBO];
   assign sleepSync  = sync_q[SYNC_ZZ];

   ////////////////////////////////////////////////////////////////////////////
   // Sleep entry and wake

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleepCnt_q <= '0;
         asleep_q   <= 1'b0;
      end else if (sleepSync != asleep_q) begin
         if (sleepCnt_q == SLEEP_CNT_MAX) begin
            asleep_q   <= sleepSync;
            sleepCnt_q <= '0;
         end else begin
            sleepCnt_q <= 2'(sleepCnt_q + 2'h1);
         end
      end else begin
         sleepCnt_q <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   // Clock gate and sleep both freeze the pipeline
   assign run      = !clockGate_n && !asleep_q;
   assign flowMode = !flowThroughSelect_n;
   assign selected = !chipSelectOne_n && chipSelectTwo && !chipSelectThree_n;
   assign loadCmd  = !burstStepOrLoad;
   assign contCmd  = burstStepOrLoad && (op_q != OP_IDLE);
   assign newRead  = loadCmd && selected && storeStrobe_n;
   assign newWrite = loadCmd && selected && !storeStrobe_n;
   assign rdNow    = newRead || (contCmd && op_q == OP_READ);
   assign wrNow    = newWrite || (contCmd && op_q == OP_WRITE);

   assign strobe_n = {byteLaneDStrobe_n, byteLaneCStrobe_n, byteLaneBStrobe_n, byteLaneAStrobe_n};
   assign laneMask = ~strobe_n & (narrowOrg ? NARROW_LANE_MASK : FULL_LANE_MASK);
   assign wrEff    = wrNow && (laneMask != '0);

   // Loaded address or counter-generated one
   assign accAddr  = loadCmd ? {addrHigh, burstStartLowBits} : {hi_q, nextBits};

   ////////////////////////////////////////////////////////////////////////////
   // Burst state

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_q <= OP_IDLE;
         hi_q <= '0;
      end else if (run && loadCmd) begin
         if (!selected) begin
            op_q <= OP_IDLE;
         end else if (storeStrobe_n) begin
            op_q <= OP_READ;
         end else begin
            op_q <= OP_WRITE;
         end
         if (selected) begin
            hi_q <= addrHigh;
         end
      end
   end

   sbsp_burst_ctr u_burst (
      .clk         (clk),
      .reset_n     (reset_n),
      .load        (run && loadCmd && selected),
      .advance     (run && contCmd),
      .linearOrder (linearSync),
      .startBits   (burstStartLowBits),
      .nextBits    (nextBits)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Late write pipeline

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrV1_q <= 1'b0;
         wrA1_q <= '0;
         wrM1_q <= '0;
         wrV2_q <= 1'b0;
         wrA2_q <= '0;
         wrM2_q <= '0;
      end else if (run) begin
         wrV1_q <= wrEff;
         wrA1_q <= accAddr;
         wrM1_q <= laneMask;
         wrV2_q <= wrV1_q;
         wrA2_q <= wrA1_q;
         wrM2_q <= wrM1_q;
      end
   end

   // Flow-through takes data one edge after the command, pipeline two
   always_comb begin
      if (flowMode) begin
         commitEn   = run && wrV1_q;
         commitAddr = wrA1_q;
         commitMask = wrM1_q;
      end else begin
         commitEn   = run && wrV2_q;
         commitAddr = wrA2_q;
         commitMask = wrM2_q;
      end
   end
   assign dataIn     = {dataLaneDIn, dataLaneCIn, dataLaneBIn, dataLaneAIn};

   sbsp_mem_core u_core (
      .clk     (clk),
      .wrEn    (commitEn),
      .wrAddr  (commitAddr),
      .wrLanes (commitMask),
      .wrData  (dataIn),
      .rdAddr  (accAddr),
      .rdData  (rdData)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data path

   // Only reads drive the bus; writes leave it off
   always_comb begin
      if (!run) begin
         driveNext = drive_q;
      end else if (flowMode) begin
         driveNext = rdNow;
      end else begin
         driveNext = rdValid1_q;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdStage_q  <= '0;
         rdValid1_q <= 1'b0;
      end else if (run) begin
         rdStage_q  <= rdData;
         rdValid1_q <= rdNow;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dataOut_q <= '0;
         drive_q   <= 1'b0;
      end else if (run) begin
         dataOut_q <= flowMode ? rdData : rdStage_q;
         drive_q   <= driveNext;
      end
   end

   // A stalled read keeps driving; sleep and output enable force off
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dataOe_q <= 1'b0;
      end else begin
         dataOe_q <= driveNext && !oeSync_n && !asleep_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign dataLaneAOut = dataOut_q[0*LANE_W +: LANE_W];
   assign dataLaneBOut = dataOut_q[1*LANE_W +: LANE_W];
   assign dataLaneCOut = dataOut_q[2*LANE_W +: LANE_W];
   assign dataLaneDOut = dataOut_q[3*LANE_W +: LANE_W];
   assign dataOe       = dataOe_q;
   assign asleep       = asleep_q;

endmodule // sbsp_port

`default_nettype wire

// *** sbsp_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbsp_port_sva
   import sbsp_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Watched inputs
   input  wire logic              clockGate_n,
   input  wire logic              chipSelectOne_n,
   input  wire logic              chipSelectTwo,
   input  wire logic              chipSelectThree_n,
   input  wire logic              storeStrobe_n,
   input  wire logic              burstStepOrLoad,
   input  wire logic              outputEnable_n,
   input  wire logic              sleepRequest,
   input  wire logic              flowThroughSelect_n,
   // Watched outputs
   input  wire logic [LANE_W-1:0] dataLaneAOut,
   input  wire logic              dataOe,
   input  wire logic              asleep
);
   logic       sel, runNow, rdLoad, quietLoad;
   logic [1:0] oeLowCnt_q;

   assign sel       = !chipSelectOne_n && chipSelectTwo && !chipSelectThree_n;
   assign runNow    = !clockGate_n && !asleep;
   assign rdLoad    = runNow && !burstStepOrLoad && sel && storeStrobe_n;
   assign quietLoad = runNow && !burstStepOrLoad && !(sel && storeStrobe_n);

   // Cycles that output enable has been held low, saturating
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) oeLowCnt_q <= 2'h0;
      else if (outputEnable_n) oeLowCnt_q <= 2'h0;
      else if (oeLowCnt_q != 2'h3) oeLowCnt_q <= oeLowCnt_q + 2'h1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////////////////////
   a_read_drive_pipe: assert property (rdLoad && oeLowCnt_q == 2'h3 && flowThroughSelect_n ##1 runNow |=> dataOe)
      else $error("pipelined read did not drive");
   a_read_drive_flow: assert property (rdLoad && oeLowCnt_q == 2'h3 && !flowThroughSelect_n |=> dataOe)
      else $error("flow read did not drive");
   a_quiet_pipe_off: assert property (quietLoad && flowThroughSelect_n ##1 runNow |=> !dataOe)
      else $error("pipelined write or deselect drove bus");
   a_quiet_flow_off: assert property (quietLoad && !flowThroughSelect_n |=> !dataOe)
      else $error("flow write or deselect drove bus");
   a_stall_holds_out: assert property (clockGate_n |=> $stable(dataOe) && $stable(dataLaneAOut))
      else $error("outputs moved during stall");
   a_oe_forces_off: assert property ((outputEnable_n && !clockGate_n) [*4] |-> !dataOe)
      else $error("bus driven with output enable high");
   a_sleep_no_drive: assert property (asleep && $past(asleep) |-> !dataOe)
      else $error("bus driven while asleep");
   a_sleep_entry_time: assert property ((sleepRequest && !clockGate_n) [*6] |=> asleep)
      else $error("sleep not entered in time");
   a_wake_time: assert property ((!sleepRequest && !clockGate_n) [*6] |=> !asleep)
      else $error("wake not reached in time");

   c_read: cover property (rdLoad ##1 dataOe);
   c_stall: cover property (clockGate_n && dataOe);
   c_sleep: cover property ($rose(asleep));
endmodule // sbsp_port_sva

bind sbsp_port sbsp_port_sva u_sva (.clk, .reset_n, .clockGate_n, .chipSelectOne_n, .chipSelectTwo,
   .chipSelectThree_n, .storeStrobe_n, .burstStepOrLoad, .outputEnable_n, .sleepRequest,
   .flowThroughSelect_n, .dataLaneAOut, .dataOe, .asleep);

`default_nettype wire

// *** sbsp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbsp_host_model
   import sbsp_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Device state seen by the host
   input  wire logic              clockGate_n,
   input  wire logic              asleep,
   input  wire logic              flowThroughSelect_n,
   // Write data handed over with the command
   input  wire logic              wrValid,
   input  wire logic [DATA_W-1:0] wrWord,
   // Device side of the data pins
   input  wire logic [DATA_W-1:0] devOut,
   input  wire logic              devOe,
   // Resolved data pins
   output logic      [DATA_W-1:0] pinBus
);
   logic [DATA_W:0]   stage1_q, stage2_q, drive;
   logic [DATA_W-1:0] junk_q;

   // Late write delay line, paused with the device
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_q <= '0;
         stage2_q <= '0;
         junk_q   <= 36'h5a5a5a5a5;
      end else begin
         junk_q <= {junk_q[DATA_W-2:0], ~junk_q[DATA_W-1]};
         if (!clockGate_n && !asleep) begin
            stage1_q <= {wrValid, wrWord};
            stage2_q <= stage1_q;
         end
      end
   end

   assign drive  = flowThroughSelect_n ? stage2_q : stage1_q;
   // Released bus shows a changing pattern, never the last value
   assign pinBus = drive[DATA_W] ? drive[DATA_W-1:0] : (devOe ? devOut : junk_q);
endmodule // sbsp_host_model

`default_nettype wire

// *** tb_sync_burst_sram_port.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_sync_burst_sram_port;
   import sbsp_pkg::*;
   logic clk = 1'b0, reset_n, clockGate_n, chipSelectOne_n, chipSelectTwo, chipSelectThree_n;
   logic storeStrobe_n, burstStepOrLoad, outputEnable_n, sleepRequest, flowThroughSelect_n, wrValid;
   logic linearOrderSelect_n, narrowOrg, byteLaneAStrobe_n, byteLaneBStrobe_n, byteLaneCStrobe_n;
   logic byteLaneDStrobe_n, dataOe, asleep, frozen;
   logic [ADDR_HI_W-1:0] addrHigh, bHi;
   logic [BURST_W-1:0]   burstStartLowBits, bStart, bStep;
   logic [LANE_W-1:0]    dataLaneAIn, dataLaneBIn, dataLaneCIn, dataLaneDIn;
   logic [LANE_W-1:0]    dataLaneAOut, dataLaneBOut, dataLaneCOut, dataLaneDOut;
   logic [DATA_W-1:0]    wrWord, pinBus, devOut, expMem [DEPTH];
   logic [DATA_W:0]      pv [2];
   logic [31:0]          lfsrQ = 32'hfac31b58, r;
   int                   err_total = 0, n_checks = 0, curOp;

   assign devOut = {dataLaneDOut, dataLaneCOut, dataLaneBOut, dataLaneAOut};
   assign {dataLaneDIn, dataLaneCIn, dataLaneBIn, dataLaneAIn} = pinBus;

   sbsp_port dut_u (.clk, .reset_n, .clockGate_n, .chipSelectOne_n, .chipSelectTwo, .chipSelectThree_n,
      .storeStrobe_n, .burstStepOrLoad, .addrHigh, .burstStartLowBits, .byteLaneAStrobe_n, .byteLaneBStrobe_n,
      .byteLaneCStrobe_n, .byteLaneDStrobe_n, .outputEnable_n, .sleepRequest, .flowThroughSelect_n,
      .linearOrderSelect_n, .narrowOrg, .dataLaneAIn, .dataLaneBIn, .dataLaneCIn, .dataLaneDIn, .dataLaneAOut,
      .dataLaneBOut, .dataLaneCOut, .dataLaneDOut, .dataOe, .asleep);
   sbsp_host_model host_u (.clk, .reset_n, .clockGate_n, .asleep, .flowThroughSelect_n, .wrValid, .wrWord,
      .devOut, .devOe(dataOe), .pinBus);

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (seen !== exp || $isunknown(exp)) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rnd(output logic [31:0] v);
      lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
      v = lfsrQ;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Kind: 0 read load, 1 write load, 2 continue, 3 deselect
   task automatic cyc(input int kind, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bn, input logic g);
      logic [31:0]       r1, r2;
      logic [LANES-1:0]  lanes;
      logic [DATA_W:0]   e;
      logic [DATA_W-1:0] m;
      rnd(r1);
      rnd(r2);
      wrWord = {r1[3:0], r2};
      wrValid = 1'b0;
      {chipSelectOne_n, chipSelectTwo, chipSelectThree_n} = (kind == 3) ? {a[1:0] == 2'h0, a[1:0] != 2'h1, a[1]} : 3'h2;
      burstStepOrLoad = (kind == 2);
      storeStrobe_n = (kind != 1);
      {addrHigh, burstStartLowBits} = a;
      {byteLaneDStrobe_n, byteLaneCStrobe_n, byteLaneBStrobe_n, byteLaneAStrobe_n} = bn;
      clockGate_n = g;
      if (!g && !frozen) begin
         pv[1] = pv[0];
         pv[0] = '0;
         if (kind < 2) begin
            curOp = kind + 1;
            bHi = a[9:2];
            bStart = a[1:0];
            bStep = 2'h0;
         end else if (kind == 3) curOp = 0;
         else bStep++;
         curAddr_blk: begin end
         if (kind != 3 && curOp == 1) pv[0] = {1'b1, expMem[{bHi, linearOrderSelect_n ? bStart ^ bStep : bStart + bStep}]};
         if (kind != 3 && curOp == 2) begin
            wrValid = 1'b1;
            lanes = ~bn & (narrowOrg ? NARROW_LANE_MASK : FULL_LANE_MASK);
            for (int i = 0; i < LANES; i++)
               if (lanes[i]) expMem[{bHi, linearOrderSelect_n ? bStart ^ bStep : bStart + bStep}][i*LANE_W +: LANE_W] = wrWord[i*LANE_W +: LANE_W];
         end
      end
      @(posedge clk);
      #1;
      e = pv[flowThroughSelect_n];
      m = narrowOrg ? 36'h3ffff : '1;
      check(DATA_W'(dataOe), DATA_W'(e[DATA_W] & !outputEnable_n));
      if (e[DATA_W] && !outputEnable_n) check(devOut & m, e[DATA_W-1:0] & m);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset_n, clockGate_n, sleepRequest, wrValid, frozen, storeStrobe_n, burstStepOrLoad, addrHigh} = '0;
      {chipSelectOne_n, chipSelectTwo, chipSelectThree_n, burstStartLowBits, wrWord} = '0;
      {byteLaneAStrobe_n, byteLaneBStrobe_n, byteLaneCStrobe_n, byteLaneDStrobe_n} = 4'hf;
      for (int p = 0; p < 4; p++) begin
         reset_n = 1'b0;
         flowThroughSelect_n = !p[0];
         linearOrderSelect_n = p[1];
         narrowOrg = p[0] ^ p[1];
         outputEnable_n = (p == 2);
         pv[0] = '0;
         pv[1] = '0;
         curOp = 0;
         repeat (2) @(posedge clk);
         #1 reset_n = 1'b1;
         repeat (3) cyc(3, 10'h0, 4'hf, 1'b0);
         // Fill the whole array once so no read sees an unwritten word
         if (p == 0)
            for (int k = 0; k < DEPTH / 4; k++) begin
               cyc(1, {k[7:0], 2'h0}, 4'h0, 1'b0);
               repeat (3) cyc(2, 10'h0, 4'h0, 1'b0);
            end
         // Burst write, then read back past the wrap with a stall inside
         rnd(r);
         cyc(1, r[9:0], 4'h0, 1'b0);
         repeat (4) cyc(2, 10'h0, 4'h0, 1'b0);
         repeat (2) cyc(3, 10'h0, 4'hf, 1'b0);
         cyc(0, r[9:0], 4'hf, 1'b0);
         for (int j = 0; j < 6; j++) cyc(2, 10'h0, 4'hf, j == 2);
         // Random mix; reads and writes of one block use opposite banks
         for (int i = 0; i < 64; i++) begin
            if (i % 16 == 0) repeat (2) cyc(3, 10'h0, 4'hf, 1'b0);
            rnd(r);
            cyc(r[1:0], {r[13:7], (r[1:0] == 2'h1) ^ i[4], r[6:5]}, r[17:14], r[20:18] == 3'h0);
         end
         repeat (2) cyc(3, 10'h0, 4'hf, 1'b0);
         if (p == 0) begin
            cyc(1, 10'h3ff, 4'h0, 1'b0);
            sleepRequest = 1'b1;
            repeat (6) cyc(3, 10'h0, 4'hf, 1'b0);
            check(DATA_W'(asleep), 36'h1);
            frozen = 1'b1;
            cyc(1, 10'h3ff, 4'h0, 1'b0);
            sleepRequest = 1'b0;
            repeat (6) cyc(3, 10'h0, 4'hf, 1'b0);
            frozen = 1'b0;
            check(DATA_W'(asleep), 36'h0);
            cyc(0, 10'h3ff, 4'hf, 1'b0);
            repeat (2) cyc(3, 10'h0, 4'hf, 1'b0);
         end
      end
      complete_run;
   end

   initial begin
      #20000;
      err_total++;
      complete_run;
   end
endmodule // tb_sync_burst_sram_port

`default_nettype wire
